// File: pdm_core_model.sv
// Processor core model that issues sleep, wakeup and watchdog events
`timescale 1ns/1ps

module pdm_core_model (
    // Clock
    input wire logic aclk,
    // Requests from the bench
    input wire logic sleep_req,
    input wire logic wake_req,
    input wire logic ovf_req,
    input wire logic rtc_start,
    input wire logic timer_from_rtc,
    // Toward the controller
    output pdm_pkg::pdm_core_t core
);
    import pdm_pkg::*;

    // Events leave on a clock edge, so a one-cycle request is a one-cycle pulse
    initial core = '0;
    always @(posedge aclk) begin
        core.sleep_exec <= sleep_req;
        core.wake_irq <= wake_req;
        core.watchdog_timer_ovf <= ovf_req;
        core.rtc_start_bit <= rtc_start;
        core.timer_from_rtc <= timer_from_rtc;
    end
endmodule : pdm_core_model

// File: pdm_ctrl.sv
// Power-down mode controller with AXI4-Lite standby control registers
//
// Overview of operation
// R1: Power-down modes halt the processor and chosen peripherals to save power.
// R2: Sleep instruction with standby select bit 0 enters sleep mode.
// R3: Sleep instruction with standby select bit 1 enters standby mode.
// R4: Module clock-stop bit 1 stops that module's clock; 0 lets it run.
// R5: Sleep keeps clock generator running; standby halts it; interrupt or reset exits. Here standby keeps it running while control bit 4 is set.
// R6: In standby, real-time counter runs if started; timer runs if fed by it.
// R7: Clock-stopped timer pin holds its state; serial pin goes to reset state.
// R8: Hardware-standby input low halts clock generator and processor until power-on reset.
// R9: In hardware standby, real-time counter runs only if started; timer stops.
// R10: State pins: reset HH, sleep HL, standby LH, normal LL.
// R11: Wakeup output low after standby wakeup interrupt until watchdog overflow.
// R12: Both standby control registers clear on power-on reset, hold on manual reset.
// R13: Both standby control registers are accessed byte-wide.
// R14: Clock-stopped modules keep contents and resume on bit clear or reset.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pdm_defines.svh"

module pdm_ctrl (
    // Clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic manual_reset_n,
    // AXI4-Lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Processor core
    input wire pdm_pkg::pdm_core_t core,
    input wire logic hw_standby_input,
    // Peripheral clock gates and pin control
    output pdm_pkg::pdm_gate_t gate,
    output logic timer_pin_hold,
    output logic serial_pin_reset,
    // Status pins
    output logic proc_state_hi,
    output logic proc_state_lo,
    output logic wakeup_n
);
    import pdm_pkg::*;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [7:0] standby_control;
    logic [7:0] standby_control_2;
    logic [7:0] next_standby_control;
    logic [7:0] next_standby_control_2;
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [31:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_write;

    // Byte lane of a register address
    function automatic logic [1:0] lane(input logic [31:0] a);
        lane = a[1:0];
    endfunction : lane

    // Only the aligned word holding a register decodes; returns 0..4
    function automatic logic [2:0] decode(input logic [31:0] a);
        logic [31:0] w;
        w = {a[31:2], 2'b00};
        if (w == (`PDM_OFS_STANDBY_SELECT_BIT_CTRL & 32'hffff_fffc)) decode = 3'd1;
        else if (w == `PDM_OFS_STANDBY_SELECT_BIT_CTRL2) decode = 3'd2;
        else if (w == `PDM_OFS_MODE_CTRL) decode = 3'd3;
        else if (w == `PDM_OFS_STATUS) decode = 3'd4;
        else decode = 3'd0;
    endfunction : decode

    pdm_mode_t mode, next_mode;
    logic hw_standby_latched, next_hw_standby_latched;
    logic pins_in_reset;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = (aw_held || (s_axi_awvalid && s_axi_awready))
        && (w_held || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;

    always_comb begin
        logic [31:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [2:0] sel;
        a = aw_held ? aw_addr : s_axi_awaddr;
        d = w_held ? w_data : s_axi_wdata;
        s = w_held ? w_strb : s_axi_wstrb;
        sel = decode(a);
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_standby_control = standby_control;
        next_standby_control_2 = standby_control_2;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `PDM_RESP_OKAY;
            // Byte lane of the register address carries the 8-bit value
            if (sel == 3'd1 && s[lane(`PDM_OFS_STANDBY_SELECT_BIT_CTRL)]) begin
                next_standby_control = d[8*lane(`PDM_OFS_STANDBY_SELECT_BIT_CTRL) +: 8]
                    & `PDM_STANDBY_SELECT_BIT_CTRL_WMASK; // R13
            end else if (sel == 3'd2 && s[lane(`PDM_OFS_STANDBY_SELECT_BIT_CTRL2)]) begin
                next_standby_control_2 = d[8*lane(`PDM_OFS_STANDBY_SELECT_BIT_CTRL2) +: 8]; // R13
            end else if (sel == 3'd0) begin
                next_bresp = `PDM_RESP_SLVERR;
            end
        end
    end

    always_comb begin
        logic [2:0] rs;
        rs = decode(s_axi_araddr);
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `PDM_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            case (rs)
                3'd1: next_rdata[8*lane(`PDM_OFS_STANDBY_SELECT_BIT_CTRL) +: 8] = standby_control;
                3'd2: next_rdata[8*lane(`PDM_OFS_STANDBY_SELECT_BIT_CTRL2) +: 8] = standby_control_2;
                3'd3: next_rdata = {31'h0, hw_standby_latched};
                3'd4: next_rdata = {26'h0, wakeup_n, proc_state_hi, proc_state_lo,
                    pins_in_reset, mode};
                default: next_rresp = `PDM_RESP_SLVERR;
            endcase
        end
    end

    // Registers clear only on power-on reset; manual reset leaves them alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_control <= `PDM_STANDBY_SELECT_BIT_CTRL_RESET; // R12
            standby_control_2 <= `PDM_STANDBY_SELECT_BIT_CTRL2_RESET; // R12
        end else begin
            standby_control <= next_standby_control;
            standby_control_2 <= next_standby_control_2;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    logic wake_set, wake_clear;

    always_comb begin
        next_mode = mode;
        next_hw_standby_latched = hw_standby_latched;
        wake_set = 1'b0;
        wake_clear = 1'b0;
        case (mode)
            PDM_MODE_NORMAL: begin
                if (core.sleep_exec) begin
                    next_mode = standby_control[`PDM_BIT_STANDBY_SELECT_BIT_SEL]
                        ? PDM_MODE_STANDBY : PDM_MODE_SLEEP; // R2 R3
                end
                if (core.watchdog_timer_ovf) begin
                    wake_clear = 1'b1; // R11
                end
            end
            PDM_MODE_SLEEP: begin
                if (core.wake_irq) begin
                    next_mode = PDM_MODE_NORMAL; // R5
                end
            end
            PDM_MODE_STANDBY: begin
                if (core.wake_irq) begin
                    next_mode = PDM_MODE_NORMAL; // R5
                    wake_set = 1'b1; // R11
                end
            end
            // Only a power-on reset leaves this state
            PDM_MODE_HW_STANDBY: next_mode = PDM_MODE_HW_STANDBY; // R8
            default: next_mode = PDM_MODE_NORMAL;
        endcase
        if (!manual_reset_n && mode != PDM_MODE_HW_STANDBY) begin
            next_mode = PDM_MODE_NORMAL; // R5
        end
        if (!hw_standby_input) begin
            next_mode = PDM_MODE_HW_STANDBY; // R8
            next_hw_standby_latched = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= PDM_MODE_NORMAL;
            hw_standby_latched <= 1'b0;
        end else begin
            mode <= next_mode;
            hw_standby_latched <= next_hw_standby_latched;
        end
    end

    assign pins_in_reset = !manual_reset_n;

    // ------------------------------------------------------------
    // Clock gating
    // ------------------------------------------------------------
    logic next_cg, next_cpu, next_tmr, next_rtc, next_ser, next_tpin, next_spin;
    logic [7:0] next_ctrl2_run;

    always_comb begin
        logic halted;
        logic cg_off;
        halted = mode == PDM_MODE_STANDBY || mode == PDM_MODE_HW_STANDBY;
        // Standby may keep the oscillator running if software asked for it
        cg_off = mode == PDM_MODE_HW_STANDBY
            || (mode == PDM_MODE_STANDBY && !standby_control[`PDM_BIT_XTAL_RUN]);
        next_cg = !cg_off; // R5 R8
        next_cpu = mode == PDM_MODE_NORMAL; // R1 R8
        next_rtc = !standby_control[`PDM_BIT_RTC_STOP]
            && (!halted || core.rtc_start_bit); // R4 R6 R9
        next_tmr = !standby_control[`PDM_BIT_TMR_STOP]
            && (mode == PDM_MODE_NORMAL || mode == PDM_MODE_SLEEP
            || (mode == PDM_MODE_STANDBY && core.timer_from_rtc && next_rtc)); // R4 R6 R9
        next_ser = !standby_control[`PDM_BIT_SER_STOP] && !halted; // R1 R4
        next_tpin = standby_control[`PDM_BIT_TMR_STOP]; // R7
        next_spin = standby_control[`PDM_BIT_SER_STOP]; // R7
        next_ctrl2_run = '0;
        for (int i = 0; i < 8; i++) begin
            // The pin-latch control bit is not a clock stop
            if (i == 6) next_ctrl2_run[i] = !halted;
            else next_ctrl2_run[i] = !standby_control_2[i] && !halted; // R4 R14
        end
    end

    // Gating only stops clocks, so module state stays put until resumed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate <= '1; // R14
            timer_pin_hold <= 1'b0;
            serial_pin_reset <= 1'b0;
        end else begin
            gate <= '{next_cg, next_cpu, next_tmr, next_rtc, next_ser, next_ctrl2_run};
            timer_pin_hold <= next_tpin;
            serial_pin_reset <= next_spin;
        end
    end

    pdm_state_pins u_pdm_state_pins (
        .aclk(aclk),
        .aresetn(aresetn),
        .mode(mode),
        .in_reset(pins_in_reset),
        .wake_set(wake_set),
        .wake_clear(wake_clear),
        .proc_state_hi(proc_state_hi),
        .proc_state_lo(proc_state_lo),
        .wakeup_n(wakeup_n)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seq_sleep_taken;
        mode == PDM_MODE_NORMAL && core.sleep_exec && hw_standby_input && manual_reset_n;
    endsequence

    chk_sleep_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        (seq_sleep_taken and !standby_control[7]) |=> mode == PDM_MODE_SLEEP)
        else $error("sleep mode not entered"); // R2

    chk_standby_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        (seq_sleep_taken and standby_control[7]) |=> mode == PDM_MODE_STANDBY)
        else $error("standby mode not entered"); // R3

    chk_clock_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        standby_control[0] |=> !gate.serial_interface_run && serial_pin_reset)
        else $error("serial clock not stopped"); // R4

    chk_hw_standby_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == PDM_MODE_HW_STANDBY |=> mode == PDM_MODE_HW_STANDBY)
        else $error("hardware standby left without power-on reset"); // R8

    chk_hw_timer_off: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == PDM_MODE_HW_STANDBY |=> !gate.timer_unit_run && !gate.cpu_run)
        else $error("timer runs in hardware standby"); // R9

    chk_regs_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        !do_write |=> $stable(standby_control) && $stable(standby_control_2))
        else $error("standby control changed without a write"); // R12

    chk_standby_cg: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == PDM_MODE_STANDBY && !standby_control[4] |=> !gate.clock_generator_run)
        else $error("clock generator runs in standby"); // R5

endmodule : pdm_ctrl

// File: pdm_ctrl_tb.sv
// Self-checking bench for the power-down mode controller
`timescale 1ns/1ps
`include "pdm_defines.svh"

module pdm_ctrl_tb;
    import pdm_pkg::*;

    logic aclk = 0, aresetn = 0, manual_reset_n = 1, hw_standby_input = 1;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic sleep_req = 0, wake_req = 0, ovf_req = 0, rtc_start = 0, tmr_rtc = 0;
    logic timer_pin_hold, serial_pin_reset, st_hi, st_lo, wakeup_n;
    pdm_core_t core;
    pdm_gate_t gate;
    int fail_count = 0, checks_done = 0, cycles = 0;

    always #25 aclk = ~aclk;

    pdm_core_model u_pdm_core_model (.aclk(aclk), .sleep_req(sleep_req), .wake_req(wake_req),
        .ovf_req(ovf_req), .rtc_start(rtc_start), .timer_from_rtc(tmr_rtc), .core(core));

    pdm_ctrl u_pdm_ctrl (.aclk(aclk), .aresetn(aresetn), .manual_reset_n(manual_reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .core(core), .hw_standby_input(hw_standby_input), .gate(gate),
        .timer_pin_hold(timer_pin_hold), .serial_pin_reset(serial_pin_reset),
        .proc_state_hi(st_hi), .proc_state_lo(st_lo), .wakeup_n(wakeup_n));

    // --------------------------------------------------------------
    // Common tasks
    // --------------------------------------------------------------
    task automatic stop_test();
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    // Hangs are cut short by the global cycle limit, not here
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (bvalid === 1'b1) break;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        resp = bresp;
        bready <= 1'b0;
        cyc(1);
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (rvalid === 1'b1) break;
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        cyc(1);
    endtask : axi_read

    // One-hot request: bit 2 sleep, bit 1 wake, bit 0 watchdog overflow
    task automatic pulse(input logic [2:0] which);
        {sleep_req, wake_req, ovf_req} <= which;
        cyc(1);
        {sleep_req, wake_req, ovf_req} <= 3'b000;
        cyc(4);
    endtask : pulse

    task automatic por();
        aresetn <= 1'b0;
        cyc(5);
        aresetn <= 1'b1;
        cyc(3);
    endtask : por

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset_state();
        logic [31:0] d;
        axi_read(`PDM_OFS_STANDBY_SELECT_BIT_CTRL, d);
        chk(d, 32'h0);
        axi_read(`PDM_OFS_STANDBY_SELECT_BIT_CTRL2, d);
        chk(d, 32'h0);
        axi_read(32'hffffff00, d);
        chk(d, 32'h0);
        chk(resp, `PDM_RESP_SLVERR);
        axi_write(32'hffffff00, 32'hffffffff, 4'hf);
        chk(resp, `PDM_RESP_SLVERR);
        chk({st_hi, st_lo, wakeup_n}, 3'b001);
        chk(gate, 13'h1fff);
    endtask : t_reset_state

    task automatic t_clock_stops();
        logic [31:0] d;
        axi_write(`PDM_OFS_STANDBY_SELECT_BIT_CTRL, 32'h00ff0000, 4'h4);
        chk(resp, `PDM_RESP_OKAY);
        axi_read(`PDM_OFS_STANDBY_SELECT_BIT_CTRL, d);
        chk({d[23:16], 6'h0, resp}, {8'h97, 6'h0, `PDM_RESP_OKAY});
        axi_write(`PDM_OFS_STANDBY_SELECT_BIT_CTRL, 32'h0, 4'h1);
        axi_read(`PDM_OFS_STANDBY_SELECT_BIT_CTRL, d);
        chk(d[23:16], 8'h97);
        axi_write(`PDM_OFS_STANDBY_SELECT_BIT_CTRL2, 32'h000000a5, 4'h1);
        axi_read(`PDM_OFS_STANDBY_SELECT_BIT_CTRL2, d);
        chk(d[7:0], 8'ha5);
        chk({gate.timer_unit_run, gate.rtc_run, gate.serial_interface_run}, 3'b000);
        chk(gate.ctrl2_run, 8'h5a);
        chk({timer_pin_hold, serial_pin_reset}, 2'b11);
        chk({gate.cpu_run, gate.clock_generator_run}, 2'b11);
        axi_write(`PDM_OFS_STANDBY_SELECT_BIT_CTRL, 32'h0, 4'h4);
        axi_write(`PDM_OFS_STANDBY_SELECT_BIT_CTRL2, 32'h0, 4'h1);
        cyc(2);
        chk({gate, timer_pin_hold, serial_pin_reset}, {13'h1fff, 2'b00});
    endtask : t_clock_stops

    task automatic t_manual_reset();
        logic [31:0] d;
        axi_write(`PDM_OFS_STANDBY_SELECT_BIT_CTRL, 32'h00970000, 4'h4);
        axi_write(`PDM_OFS_STANDBY_SELECT_BIT_CTRL2, 32'h0000003c, 4'h1);
        manual_reset_n <= 1'b0;
        cyc(3);
        chk({st_hi, st_lo}, `PDM_ST_RESET);
        manual_reset_n <= 1'b1;
        cyc(3);
        axi_read(`PDM_OFS_STANDBY_SELECT_BIT_CTRL, d);
        chk(d[23:16], 8'h97);
        axi_read(`PDM_OFS_STANDBY_SELECT_BIT_CTRL2, d);
        chk(d[7:0], 8'h3c);
        por();
        axi_read(`PDM_OFS_STANDBY_SELECT_BIT_CTRL, d);
        chk(d[23:16], 8'h00);
        axi_read(`PDM_OFS_STANDBY_SELECT_BIT_CTRL2, d);
        chk(d[7:0], 8'h00);
    endtask : t_manual_reset

    task automatic t_sleep();
        logic [31:0] d;
        pulse(3'b100);
        chk({st_hi, st_lo}, `PDM_ST_SLEEP);
        chk({gate.cpu_run, gate.clock_generator_run, gate.timer_unit_run}, 3'b011);
        axi_read(`PDM_OFS_STATUS, d);
        chk(d, 32'h0000_0031);
        pulse(3'b010);
        chk({st_hi, st_lo, wakeup_n, gate.cpu_run}, 4'b0011);
    endtask : t_sleep

    task automatic t_standby();
        axi_write(`PDM_OFS_STANDBY_SELECT_BIT_CTRL, 32'h00800000, 4'h4);
        for (int i = 0; i < 2; i++) begin
            rtc_start <= i[0];
            tmr_rtc <= i[0];
            pulse(3'b100);
            chk({st_hi, st_lo}, `PDM_ST_STANDBY);
            chk({gate.clock_generator_run, gate.cpu_run}, 2'b00);
            chk({gate.rtc_run, gate.timer_unit_run}, {i[0], i[0]});
            pulse(3'b010);
            chk({st_hi, st_lo, wakeup_n}, 3'b000);
            cyc(6);
            chk(wakeup_n, 1'b0);
            pulse(3'b001);
            chk(wakeup_n, 1'b1);
        end
    endtask : t_standby

    task automatic t_hw_standby();
        logic [31:0] d;
        rtc_start <= 1'b1;
        tmr_rtc <= 1'b1;
        hw_standby_input <= 1'b0;
        cyc(4);
        chk({st_hi, st_lo}, `PDM_ST_STANDBY);
        chk({gate.clock_generator_run, gate.cpu_run}, 2'b00);
        chk({gate.rtc_run, gate.timer_unit_run}, 2'b10);
        axi_read(`PDM_OFS_MODE_CTRL, d);
        chk(d, 32'h0000_0001);
        hw_standby_input <= 1'b1;
        pulse(3'b010);
        chk({st_hi, st_lo, gate.cpu_run}, 3'b010);
        por();
        chk({st_hi, st_lo, gate.cpu_run}, 3'b001);
    endtask : t_hw_standby

    // --------------------------------------------------------------
    // Main sequence and hang limit
    // --------------------------------------------------------------
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        cyc(5);
        aresetn <= 1'b1;
        cyc(3);
        t_reset_state();
        t_clock_stops();
        t_manual_reset();
        t_sleep();
        t_standby();
        t_hw_standby();
        stop_test();
    end
endmodule : pdm_ctrl_tb

// File: pdm_defines.svh
// Register offsets, field positions, reset values, state pin codes and response codes for power-down control
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

`define PDM_OFS_STANDBY_SELECT_BIT_CTRL 32'hffffff82
`define PDM_OFS_STANDBY_SELECT_BIT_CTRL2 32'hffffff88
`define PDM_OFS_MODE_CTRL 32'hffffff90
`define PDM_OFS_STATUS 32'hffffff94

`define PDM_STANDBY_SELECT_BIT_CTRL_RESET 8'h00
`define PDM_STANDBY_SELECT_BIT_CTRL2_RESET 8'h00
`define PDM_STANDBY_SELECT_BIT_CTRL_WMASK 8'h97

`define PDM_BIT_STANDBY_SELECT_BIT_SEL 7
`define PDM_BIT_XTAL_RUN 4
`define PDM_BIT_TMR_STOP 2
`define PDM_BIT_RTC_STOP 1
`define PDM_BIT_SER_STOP 0
`define PDM_BIT_XY_STOP 7

`define PDM_ST_RESET 2'b11
`define PDM_ST_SLEEP 2'b10
`define PDM_ST_STANDBY 2'b01
`define PDM_ST_NORMAL 2'b00

`define PDM_RESP_OKAY 2'b00
`define PDM_RESP_SLVERR 2'b10

`endif

// File: pdm_pkg.sv
// Types shared by the power-down mode controller
package pdm_pkg;

    typedef enum logic [1:0] {
        PDM_MODE_NORMAL,
        PDM_MODE_SLEEP,
        PDM_MODE_STANDBY,
        PDM_MODE_HW_STANDBY
    } pdm_mode_t;

    // Clock enables toward the peripheral modules
    typedef struct packed {
        logic clock_generator_run;
        logic cpu_run;
        logic timer_unit_run;
        logic rtc_run;
        logic serial_interface_run;
        logic [7:0] ctrl2_run;
    } pdm_gate_t;

    // Processor-side requests and context
    typedef struct packed {
        logic sleep_exec;
        logic wake_irq;
        logic watchdog_timer_ovf;
        logic rtc_start_bit;
        logic timer_from_rtc;
    } pdm_core_t;

endpackage : pdm_pkg

// File: pdm_state_pins.sv
// Processor-state and wakeup pin driver
`timescale 1ns/1ps
`include "pdm_defines.svh"

module pdm_state_pins (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Mode and wakeup
    input wire pdm_pkg::pdm_mode_t mode,
    input wire logic in_reset,
    input wire logic wake_set,
    input wire logic wake_clear,
    // Pins
    output logic proc_state_hi,
    output logic proc_state_lo,
    output logic wakeup_n
);
    import pdm_pkg::*;

    logic [1:0] next_state_pins;
    logic next_wakeup_n;

    function automatic logic [1:0] state_code(input pdm_mode_t m);
        case (m)
            PDM_MODE_SLEEP: state_code = `PDM_ST_SLEEP;
            PDM_MODE_STANDBY: state_code = `PDM_ST_STANDBY;
            PDM_MODE_HW_STANDBY: state_code = `PDM_ST_STANDBY;
            default: state_code = `PDM_ST_NORMAL;
        endcase
    endfunction : state_code

    always_comb begin
        next_state_pins = in_reset ? `PDM_ST_RESET : state_code(mode); // R10
        next_wakeup_n = wakeup_n;
        if (wake_clear) begin
            next_wakeup_n = 1'b1;
        end
        // Wakeup held low from the accepted standby interrupt until the watchdog overflow
        if (wake_set) begin
            next_wakeup_n = 1'b0; // R11
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            proc_state_hi <= 1'b1;
            proc_state_lo <= 1'b1;
            wakeup_n <= 1'b1;
        end else begin
            proc_state_hi <= next_state_pins[1];
            proc_state_lo <= next_state_pins[0];
            wakeup_n <= next_wakeup_n;
        end
    end

    chk_state_code_map: assert property (@(posedge aclk) disable iff (!aresetn)
        !in_reset && mode == PDM_MODE_SLEEP |=> {proc_state_hi, proc_state_lo} == 2'b10)
        else $error("sleep state code wrong"); // R10

    chk_wakeup_held_low: assert property (@(posedge aclk) disable iff (!aresetn)
        wake_set |=> !wakeup_n)
        else $error("wakeup not asserted after interrupt"); // R11

endmodule : pdm_state_pins
